/* core/utfic_pkg.sv */
// Constants and carrier types for the transmit buffer and interrupt block
package utfic_pkg;

	localparam int AW = 6;
	localparam int DW = 8;

	// Register offsets
	localparam logic [AW-1:0] OFS_DATA = 6'h00;
	localparam logic [AW-1:0] OFS_IER = 6'h01;
	localparam logic [AW-1:0] OFS_FCR = 6'h02;
	localparam logic [AW-1:0] OFS_LSR = 6'h05;
	localparam logic [AW-1:0] OFS_MSR = 6'h06;
	localparam logic [AW-1:0] OFS_SHADOW0 = 6'h20;
	localparam logic [AW-1:0] OFS_SHADOW1 = 6'h21;

	// Interrupt enable fields
	localparam int IER_RDA = 0;
	localparam int IER_THRE = 1;
	localparam int IER_RLS = 2;
	localparam int IER_MS = 3;
	localparam int IER_W = 4;
	localparam logic [IER_W-1:0] IER_RESET = 4'h0;

	// FIFO control fields
	localparam int FCR_EN = 0;
	localparam int FCR_RXCLR = 1;
	localparam int FCR_TXCLR = 2;
	localparam int FCR_TRIG_LO = 6;
	localparam int FCR_TRIG_HI = 7;
	localparam logic [DW-1:0] FCR_RESET = 8'h00;

	// Identification codes, bits 3:0
	localparam logic [3:0] IID_NONE = 4'h1;
	localparam logic [3:0] IID_RLS = 4'h6;
	localparam logic [3:0] IID_RDA = 4'h4;
	localparam logic [3:0] IID_CTO = 4'hc;
	localparam logic [3:0] IID_THRE = 4'h2;
	localparam logic [3:0] IID_MS = 4'h0;

	// Receive trigger levels in bytes
	localparam logic [4:0] TRIG_L0 = 5'h01;
	localparam logic [4:0] TRIG_L1 = 5'h04;
	localparam logic [4:0] TRIG_L2 = 5'h08;
	localparam logic [4:0] TRIG_L3 = 5'h0e;

	// Character times of silence before a timeout
	localparam logic [2:0] TO_CHARS = 3'h4;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic wr;
		logic rd;
	} utfic_bus_s;

endpackage

/* core/utfic_core.sv */
// Transmit holding FIFO, FIFO control and prioritised interrupt ident
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module utfic_core import utfic_pkg::*; #(
	parameter int TX_DEPTH = 16,
	parameter int CW = 5,
	parameter logic [AW-1:0] SHADOW_OFS = OFS_SHADOW0
) (
	input wire logic SYS_CLK_I, // Core clock
	input wire logic SYS_RST_I, // Async reset, high
	input wire utfic_bus_s BUS_I, // Register request
	output logic [DW-1:0] RD_DATA_O, // Read data, next cycle
	input wire logic DIVISOR_LATCH_SELECT_I, // divisor_latch_select
	input wire logic IRQ_GATE_I, // irq_output_gate
	input wire logic LS_ERR_I, // Line error event pulse
	input wire logic MS_CHG_I, // Modem status change pulse
	input wire logic [CW-1:0] RX_LEVEL_I, // Receive FIFO fill
	input wire logic RX_PUSH_I, // Byte entered receive FIFO
	input wire logic CHAR_TICK_I, // One character time
	input wire logic TX_IDLE_I, // Shifter finished
	output logic [DW-1:0] TX_DATA_O, // Byte for shifter
	output logic TX_LOAD_O, // Shifter load pulse
	output logic FIFO_EN_O, // FIFO mode
	output logic RX_FLUSH_O, // Receive FIFO flush pulse
	output logic IRQ_O // Serial port interrupt
);

	localparam int PW = $clog2(TX_DEPTH);

	function automatic logic hit(input logic [AW-1:0] a,
		input logic [AW-1:0] o);
		hit = (a == o);
	endfunction

	function automatic logic [4:0] trig_lvl(input logic [1:0] s);
		case (s)
			2'b00: trig_lvl = TRIG_L0;
			2'b01: trig_lvl = TRIG_L1;
			2'b10: trig_lvl = TRIG_L2;
			default: trig_lvl = TRIG_L3;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Address decode
	logic wr_thr, wr_ier, wr_fcr;
	logic rd_rbr, rd_ier, rd_iir, rd_lsr, rd_msr, rd_shd;
	assign wr_thr = BUS_I.wr && !DIVISOR_LATCH_SELECT_I && hit(BUS_I.addr, OFS_DATA);
	assign wr_ier = BUS_I.wr && !DIVISOR_LATCH_SELECT_I && hit(BUS_I.addr, OFS_IER);
	assign wr_fcr = BUS_I.wr && hit(BUS_I.addr, OFS_FCR);
	assign rd_rbr = BUS_I.rd && !DIVISOR_LATCH_SELECT_I && hit(BUS_I.addr, OFS_DATA);
	assign rd_ier = BUS_I.rd && !DIVISOR_LATCH_SELECT_I && hit(BUS_I.addr, OFS_IER);
	assign rd_iir = BUS_I.rd && hit(BUS_I.addr, OFS_FCR);
	assign rd_lsr = BUS_I.rd && hit(BUS_I.addr, OFS_LSR);
	assign rd_msr = BUS_I.rd && hit(BUS_I.addr, OFS_MSR);
	assign rd_shd = BUS_I.rd && hit(BUS_I.addr, SHADOW_OFS);

	////////////////////////////////////////////////////////////////////////
	// Enable and FIFO control
	logic [IER_W-1:0] ier_ff;
	logic [DW-1:0] fcr_shd_ff;
	logic [1:0] trig_ff;
	logic fifo_en_ff;
	logic rx_clr, tx_clr, en_bit;
	assign en_bit = BUS_I.wdata[FCR_EN];
	// Any write with en clear, setting en from off, or explicit clear flushes; other bits need en set
	assign rx_clr = wr_fcr && (!en_bit || !fifo_en_ff ||
		BUS_I.wdata[FCR_RXCLR]);
	assign tx_clr = wr_fcr && (!en_bit || !fifo_en_ff ||
		BUS_I.wdata[FCR_TXCLR]);

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ier_ff <= IER_RESET;
		end else if (wr_ier) begin
			ier_ff <= BUS_I.wdata[IER_W-1:0];
		end
	end

	// Bit 3 and bits 5:4 are stored in the shadow only
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			fcr_shd_ff <= FCR_RESET;
			fifo_en_ff <= 1'b0;
			trig_ff <= 2'b00;
		end else if (wr_fcr) begin
			fcr_shd_ff <= BUS_I.wdata;
			fifo_en_ff <= en_bit;
			if (en_bit) begin
				trig_ff <= BUS_I.wdata[FCR_TRIG_HI:FCR_TRIG_LO];
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			RX_FLUSH_O <= 1'b0;
			FIFO_EN_O <= 1'b0;
		end else begin
			RX_FLUSH_O <= rx_clr;
			FIFO_EN_O <= wr_fcr ? en_bit : fifo_en_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit holding store; depth one outside FIFO mode
	logic [DW-1:0] tx_mem [TX_DEPTH];
	logic [PW-1:0] wp_ff, rp_ff;
	logic [PW:0] cnt_ff, cap;
	logic tx_full, tx_empty, push, pop;
	assign cap = fifo_en_ff ? (PW+1)'(TX_DEPTH) : (PW+1)'(1);
	assign tx_full = cnt_ff >= cap;
	assign tx_empty = cnt_ff == '0;
	assign push = wr_thr && !tx_full;
	// One idle cycle after a load lets the shifter report busy
	assign pop = !tx_empty && TX_IDLE_I && !TX_LOAD_O;

	always_ff @(posedge SYS_CLK_I) begin
		if (push) begin
			tx_mem[wp_ff] <= BUS_I.wdata;
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else if (tx_clr) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wp_ff <= wp_ff + 1'b1;
			end
			if (pop) begin
				rp_ff <= rp_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// Shifter contents untouched by a flush
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			TX_DATA_O <= '0;
			TX_LOAD_O <= 1'b0;
		end else begin
			TX_LOAD_O <= pop;
			if (pop) begin
				TX_DATA_O <= tx_mem[rp_ff];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt sources; a set wins over a clear
	logic ls_ff, ms_ff, thre_ff, to_ff, empty_q_ff, then_q_ff;
	logic [2:0] to_cnt_ff;
	logic rda, thre_set, to_hold, to_inc;
	logic [3:0] iid;

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ls_ff <= 1'b0;
			ms_ff <= 1'b0;
		end else begin
			ls_ff <= LS_ERR_I || (ls_ff && !rd_lsr);
			ms_ff <= MS_CHG_I || (ms_ff && !rd_msr);
		end
	end

	// Level source, drops once the FIFO falls below trigger, or once it is empty outside FIFO mode
	assign rda = fifo_en_ff ? (RX_LEVEL_I >= CW'(trig_lvl(trig_ff)))
		: (RX_LEVEL_I != '0);

	assign to_hold = !fifo_en_ff || RX_LEVEL_I == '0 || RX_PUSH_I
		|| rd_rbr;
	assign to_inc = !to_hold && CHAR_TICK_I && to_cnt_ff != TO_CHARS;

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			to_cnt_ff <= '0;
			to_ff <= 1'b0;
		end else begin
			if (to_hold) begin
				to_cnt_ff <= '0;
			end else if (to_inc) begin
				to_cnt_ff <= to_cnt_ff + 1'b1;
			end
			if (to_inc && to_cnt_ff == TO_CHARS - 3'h1) begin
				to_ff <= 1'b1;
			end else if (rd_rbr || !fifo_en_ff || RX_LEVEL_I == '0) begin
				to_ff <= 1'b0;
			end
		end
	end

	// Empty edge, or enable raised while already empty
	assign thre_set = ier_ff[IER_THRE] && tx_empty &&
		(!empty_q_ff || !then_q_ff);

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			thre_ff <= 1'b0;
			empty_q_ff <= 1'b1;
			then_q_ff <= 1'b0;
		end else begin
			empty_q_ff <= tx_empty;
			then_q_ff <= ier_ff[IER_THRE];
			thre_ff <= thre_set || (thre_ff && !push &&
				!(rd_iir && iid == IID_THRE));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Priority encode and outputs
	always_comb begin
		if (ls_ff && ier_ff[IER_RLS]) begin
			iid = IID_RLS;
		end else if (rda && ier_ff[IER_RDA]) begin
			iid = IID_RDA;
		end else if (to_ff && ier_ff[IER_RDA]) begin
			iid = IID_CTO;
		end else if (thre_ff && ier_ff[IER_THRE]) begin
			iid = IID_THRE;
		end else if (ms_ff && ier_ff[IER_MS]) begin
			iid = IID_MS;
		end else begin
			iid = IID_NONE;
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			IRQ_O <= 1'b0;
		end else begin
			IRQ_O <= IRQ_GATE_I && iid != IID_NONE;
		end
	end

	// Ident snapshot taken at the strobe and kept for the next cycle only
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			RD_DATA_O <= '0;
		end else if (rd_iir) begin
			RD_DATA_O <= {{2{fifo_en_ff}}, 2'b00, iid};
		end else if (rd_ier) begin
			RD_DATA_O <= {{(DW-IER_W){1'b0}}, ier_ff};
		end else if (rd_shd) begin
			RD_DATA_O <= fcr_shd_ff;
		end else begin
			RD_DATA_O <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (SYS_RST_I);

	AST_LOAD_IDLE: assert property (TX_LOAD_O |-> $past(TX_IDLE_I)
		&& !$past(TX_LOAD_O)) else $error("load while shifter busy");
	AST_IER_HI: assert property (rd_ier |=> RD_DATA_O[7:4] == 4'h0
		&& RD_DATA_O[3:0] == $past(ier_ff)) else $error("bad enable read");
	AST_NO_EN: assert property (ier_ff == '0 ##1 ier_ff == '0
		|-> !IRQ_O) else $error("irq with enables clear");
	AST_DIS_FLUSH: assert property (wr_fcr && !en_bit |=>
		RX_FLUSH_O && cnt_ff == '0 && !FIFO_EN_O) else $error("no flush");
	AST_TX_CLR: assert property (wr_fcr && en_bit && fifo_en_ff &&
		BUS_I.wdata[FCR_TXCLR] |=> cnt_ff == '0) else $error("tx not clr");
	AST_SHADOW: assert property (wr_fcr ##1 rd_shd |=>
		RD_DATA_O == $past(BUS_I.wdata, 2)) else $error("shadow wrong");
	AST_PRIO: assert property (ls_ff && ier_ff[IER_RLS] && rd_iir
		|=> RD_DATA_O[3:0] == IID_RLS) else $error("priority wrong");
	AST_IIR: assert property (rd_iir |=> RD_DATA_O[0] ==
		($past(iid) == IID_NONE) && RD_DATA_O[7:6] ==
		{2{$past(fifo_en_ff)}} && RD_DATA_O[5:4] == 2'b00)
		else $error("ident wrong");
	AST_CTO_MODE: assert property (rd_iir && !fifo_en_ff |=>
		!RD_DATA_O[3]) else $error("bit3 outside FIFO mode");
	AST_TO_CLR: assert property (rd_rbr |=> !to_ff)
		else $error("timeout not cleared");
	AST_THRE_CLR: assert property (push && !thre_set |=> !thre_ff)
		else $error("empty not cleared by write");
	AST_GATE: assert property (!IRQ_GATE_I |=> !IRQ_O)
		else $error("irq with gate low");

	COV_LOAD: cover property (push ##[1:20] TX_LOAD_O);
	COV_CTO: cover property (rd_iir && iid == IID_CTO);
	COV_IRQ: cover property (IRQ_O ##1 rd_iir);

endmodule

/* verif/utfic_shift_model.sv */
// Transmit shift register model standing beside the holding store
module utfic_shift_model (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset, high
	input wire logic load_i, // Load pulse
	input wire logic [7:0] data_i, // Byte to shift
	input wire logic slow_i, // Long shift time
	output logic idle_o // Can take a byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$];
	int cnt;
	// Busy from the cycle after a load until the shift time ends
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			idle_o <= 1'b1;
			cnt <= 0;
		end else if (load_i === 1'b1) begin
			got.push_back(data_i);
			idle_o <= 1'b0;
			cnt <= slow_i ? 40 : 3;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else begin
			idle_o <= 1'b1;
		end
	end
endmodule

/* verif/utfic_core_tb_top.sv */
// Self-checking bench for the transmit buffer and interrupt block
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
$display("Error %0t: got %h exp %h", $time, a, e); end end
module utfic_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import utfic_pkg::*;
	logic clk = 0, rst = 1, divisor_latch_select = 0, gate = 0, slow = 0;
	logic tk = 0, push = 0, ms = 0, ls = 0;
	logic idle, load, fen, fl, irq;
	logic [4:0] lev = 0;
	logic [7:0] rdd, txd, b;
	logic [7:0] q[$];
	utfic_bus_s bus = '0;
	int n_fail = 0, checks_done = 0, seed = 33, nfl = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) if (fl === 1'b1) nfl++;
	utfic_core utfic_core_inst (.SYS_CLK_I(clk), .SYS_RST_I(rst),
		.BUS_I(bus), .RD_DATA_O(rdd), .DIVISOR_LATCH_SELECT_I(divisor_latch_select), .IRQ_GATE_I(gate),
		.LS_ERR_I(ls), .MS_CHG_I(ms), .RX_LEVEL_I(lev), .RX_PUSH_I(push),
		.CHAR_TICK_I(tk), .TX_IDLE_I(idle), .TX_DATA_O(txd),
		.TX_LOAD_O(load), .FIFO_EN_O(fen), .RX_FLUSH_O(fl), .IRQ_O(irq));
	utfic_shift_model utfic_shift_model_inst (.clk_i(clk), .rst_i(rst),
		.load_i(load), .data_i(txd), .slow_i(slow), .idle_o(idle));
	////////////////////////////////////////////////////////////////////
	function logic [7:0] iid(logic f, logic [3:0] c);
		return {f, f, 2'b00, c};
	endfunction
	function logic [4:0] trg(int k);
		return k == 0 ? 5'h01 : k == 1 ? 5'h04 : k == 2 ? 5'h08 : 5'h0e;
	endfunction
	// Returns just after the edge so registered outputs have settled
	task cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(logic [5:0] a, logic [7:0] d);
		@(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) bus.wr <= 1'b0;
		#1;
	endtask
	// Expected all x means the read data is not compared
	task rd(logic [5:0] a, logic [7:0] e);
		@(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) bus.rd <= 1'b0;
		#1;
		if (e !== 8'hxx) `CHK(rdd, e)
	endtask
	task pls(logic [3:0] m);
		@(posedge clk) {tk, push, ms, ls} <= m;
		@(posedge clk) {tk, push, ms, ls} <= 4'h0;
	endtask
	task tick(int n);
		repeat (n) pls(4'h8);
	endtask
	task wsz(int n);
		for (int i = 0; i < 200 && utfic_shift_model_inst.got.size() < n;
			i++) @(posedge clk);
	endtask
	task complete_run;
		if (n_fail == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		complete_run;
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		rd(OFS_IER, 8'h00);
		rd(OFS_FCR, iid(0, IID_NONE));
		@(posedge clk) gate <= 1;
		pls(4'h3);
		cyc(3);
		`CHK(irq, 1'b0)
		rd(OFS_FCR, iid(0, IID_NONE));
		rd(OFS_LSR, 8'hxx);
		rd(OFS_MSR, 8'hxx);
		wr(OFS_IER, 8'hff);
		rd(OFS_IER, 8'h0f);
		@(posedge clk) gate <= 0;
		pls(4'h3);
		cyc(3);
		`CHK(irq, 1'b0)
		@(posedge clk) gate <= 1;
		cyc(3);
		`CHK(irq, 1'b1)
		rd(OFS_FCR, iid(0, IID_RLS));
		rd(OFS_LSR, 8'hxx);
		rd(OFS_FCR, iid(0, IID_THRE));
		rd(OFS_FCR, iid(0, IID_MS));
		rd(OFS_MSR, 8'hxx);
		rd(OFS_FCR, iid(0, IID_NONE));
		cyc(2);
		`CHK(irq, 1'b0)
		@(posedge clk) divisor_latch_select <= 1;
		wr(OFS_IER, 8'h00);
		wr(OFS_DATA, 8'h5a);
		@(posedge clk) divisor_latch_select <= 0;
		cyc(20);
		rd(OFS_IER, 8'h0f);
		`CHK(utfic_shift_model_inst.got.size(), 0)
		wr(OFS_IER, 8'h00);
		wr(OFS_FCR, 8'h81);
		wr(OFS_FCR, 8'h83);
		wr(OFS_FCR, 8'h41);
		`CHK(fen, 1'b1)
		rd(OFS_SHADOW0, 8'h41);
		rd(6'h3f, 8'h00);
		rd(OFS_FCR, iid(1, IID_NONE));
		`CHK(nfl, 2)
		wr(OFS_IER, 8'h02);
		rd(OFS_FCR, iid(1, IID_THRE));
		for (int i = 0; i < 4; i++) begin
			b = $random(seed);
			q.push_back(b);
			wr(OFS_DATA, b);
		end
		wsz(4);
		foreach (q[i]) `CHK(utfic_shift_model_inst.got[i], q[i])
		rd(OFS_FCR, iid(1, IID_THRE));
		rd(OFS_FCR, iid(1, IID_NONE));
		@(posedge clk) slow <= 1;
		for (int i = 0; i < 3; i++) wr(OFS_DATA, 8'(8'ha0 + i));
		wr(OFS_FCR, 8'h85);
		cyc(120);
		`CHK(utfic_shift_model_inst.got.size(), 5)
		`CHK(utfic_shift_model_inst.got[4], 8'ha0)
		@(posedge clk) slow <= 0;
		wr(OFS_FCR, 8'h00);
		`CHK(fen, 1'b0)
		wr(OFS_IER, 8'h01);
		for (int k = 0; k < 4; k++) begin
			wr(OFS_FCR, {k[1:0], 6'h01});
			@(posedge clk) lev <= trg(k) - 5'h01;
			cyc(3);
			rd(OFS_FCR, iid(1, IID_NONE));
			@(posedge clk) lev <= trg(k);
			cyc(3);
			rd(OFS_FCR, iid(1, IID_RDA));
		end
		wr(OFS_FCR, 8'hc1);
		@(posedge clk) lev <= 5'h01;
		tick(3);
		pls(4'h4);
		tick(3);
		rd(OFS_FCR, iid(1, IID_NONE));
		tick(1);
		cyc(2);
		rd(OFS_FCR, iid(1, IID_CTO));
		`CHK(irq, 1'b1)
		rd(OFS_DATA, 8'hxx);
		rd(OFS_FCR, iid(1, IID_NONE));
		complete_run;
	end
endmodule
